// ---- bridge_memory_window_decode.v ----
/*
  Memory window decode of a virtual bridge: four window registers and a
  few control, status and count registers on an AXI4-Lite slave, plus a
  registered route decision for each processor memory access.
  Assumes one clock, synchronous active-low reset, and that the processor
  side offers at most one access per cycle and needs no back-pressure.
*/
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "bridge_window_defs.vh"

module bridge_memory_window_decode (
  input wire aclk,
  input wire aresetn,
  input wire [11:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire cpu_mem_valid,
  input wire [31:0] cpu_mem_addr,
  output wire route_valid,
  output wire [31:0] route_addr,
  output wire route_to_secondary,
  output wire route_to_other,
  output wire write_combining_attr,
  output wire uncached_attr
);

  // Window register indices packed for the generate loop
  localparam [39:0] WIN_IDX = {`PFW_LIMIT_IDX, `PFW_BASE_IDX,
                               `NPW_LIMIT_IDX, `NPW_BASE_IDX};

  // ==========================================================
  // Declarations
  // ==========================================================
  reg [9:0] aw_idx_reg;
  reg aw_held_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;
  reg w_held_reg;
  reg bvalid_reg;
  reg [1:0] bresp_reg;
  reg rvalid_reg;
  reg [1:0] rresp_reg;
  reg [31:0] rdata_reg;
  reg [31:0] rdata_next;
  reg [1:0] rresp_next;
  reg [1:0] ctrl_reg;
  reg clear_pulse_reg;
  reg route_valid_reg;
  reg [31:0] route_addr_reg;
  reg route_secondary_reg;
  reg route_other_reg;
  reg route_wc_reg;
  reg route_uc_reg;
  reg [1:0] last_result_reg;
  reg [`COUNT_W-1:0] np_count_reg;
  reg [`COUNT_W-1:0] pf_count_reg;
  reg [`COUNT_W-1:0] other_count_reg;
  reg [1:0] wr_resp_next;
  wire do_write;
  wire ar_take;
  wire [9:0] ar_idx;
  wire [63:0] win_values;
  wire np_hit;
  wire pf_hit;
  wire decode_on;
  wire take_np;
  wire take_pf;
  wire take_other;
  wire ctrl_sel;

  // ==========================================================
  // AXI4-Lite write channels
  // ==========================================================
  // Address and data are held separately so either may come first;
  // neither is accepted again until the response has been taken.
  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready = !w_held_reg && !bvalid_reg;
  assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

  // Capture of the write address
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_idx_reg <= 10'h000;
      aw_held_reg <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_idx_reg <= s_axi_awaddr[11:2];
      aw_held_reg <= 1'b1;
    end else if (do_write) begin
      aw_held_reg <= 1'b0;
    end
  end

  // Capture of the write data and strobes
  always @(posedge aclk) begin
    if (!aresetn) begin
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      w_held_reg <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
      w_held_reg <= 1'b1;
    end else if (do_write) begin
      w_held_reg <= 1'b0;
    end
  end

  // Unmapped write answers with a decode error and changes nothing
  always @* begin
    case (aw_idx_reg)
      `NPW_BASE_IDX, `NPW_LIMIT_IDX, `PFW_BASE_IDX, `PFW_LIMIT_IDX,
      `DECODE_CTRL_IDX, `DECODE_STATUS_IDX, `NPW_COUNT_IDX,
      `PFW_COUNT_IDX, `OTHER_COUNT_IDX: begin
        wr_resp_next = `RESP_OKAY;
      end
      default: begin
        wr_resp_next = `RESP_DECERR;
      end
    endcase
  end

  // Write response, held until the master takes it
  always @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= `RESP_OKAY;
    end else if (do_write) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_resp_next;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // ==========================================================
  // Window registers, one per entry
  // ==========================================================
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_win
      wire sel;
      assign sel = do_write && (aw_idx_reg == WIN_IDX[gi*10 +: 10]);
      window_field #(
        .RESET_VALUE(((gi % 2) == 0) ? `WIN_BASE_RESET : `WIN_LIMIT_RESET)
      ) u_field (
        .aclk(aclk),
        .aresetn(aresetn),
        .wr_en(sel),
        .wr_strb(w_strb_reg[1:0]),
        .wr_data(w_data_reg[15:0]),
        .reg_value(win_values[gi*16 +: 16])
      );
    end
  endgenerate

  // ==========================================================
  // Control register: decode enable and count clear
  // ==========================================================
  assign ctrl_sel = do_write && (aw_idx_reg == `DECODE_CTRL_IDX)
                    && w_strb_reg[0];
  assign decode_on = ctrl_reg[`CTRL_ENABLE_BIT];

  // Clear bit is a self-clearing pulse, it never reads back as one
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= `CTRL_RESET;
      clear_pulse_reg <= 1'b0;
    end else if (ctrl_sel) begin
      ctrl_reg[`CTRL_ENABLE_BIT] <= w_data_reg[`CTRL_ENABLE_BIT];
      clear_pulse_reg <= w_data_reg[`CTRL_CLEAR_BIT];
    end else begin
      clear_pulse_reg <= 1'b0;
    end
  end

  // ==========================================================
  // Address decode against both windows
  // ==========================================================
  window_match u_np_match (
    .addr(cpu_mem_addr),
    .base_field(win_values[15:4]),
    .limit_field(win_values[31:20]),
    .hit(np_hit)
  );

  window_match u_pf_match (
    .addr(cpu_mem_addr),
    .base_field(win_values[47:36]),
    .limit_field(win_values[63:52]),
    .hit(pf_hit)
  );

  // Overlap is not checked; the non-prefetchable window simply wins,
  // which keeps the decode defined without spending logic on it.
  assign take_np = cpu_mem_valid && decode_on && np_hit;
  assign take_pf = cpu_mem_valid && decode_on && !np_hit && pf_hit;
  assign take_other = cpu_mem_valid && !take_np && !take_pf;

  // Route decision, one cycle after the access
  always @(posedge aclk) begin
    if (!aresetn) begin
      route_valid_reg <= 1'b0;
      route_addr_reg <= 32'h0000_0000;
      route_secondary_reg <= 1'b0;
      route_other_reg <= 1'b0;
      route_wc_reg <= 1'b0;
      route_uc_reg <= 1'b0;
    end else begin
      route_valid_reg <= cpu_mem_valid;
      route_addr_reg <= cpu_mem_addr;
      route_secondary_reg <= take_np || take_pf;
      route_other_reg <= take_other;
      route_wc_reg <= take_pf;
      route_uc_reg <= take_np;
    end
  end

  assign route_valid = route_valid_reg;
  assign route_addr = route_addr_reg;
  assign route_to_secondary = route_secondary_reg;
  assign route_to_other = route_other_reg;
  assign write_combining_attr = route_wc_reg;
  assign uncached_attr = route_uc_reg;

  // ==========================================================
  // Decode statistics
  // ==========================================================
  // A count bumped in the clear cycle restarts at one, not zero,
  // so no access is lost to a clear that arrives with it.
  always @(posedge aclk) begin
    if (!aresetn) begin
      np_count_reg <= {`COUNT_W{1'b0}};
      pf_count_reg <= {`COUNT_W{1'b0}};
      other_count_reg <= {`COUNT_W{1'b0}};
      last_result_reg <= 2'h0;
    end else begin
      if (clear_pulse_reg) begin
        np_count_reg <= {{(`COUNT_W-1){1'b0}}, take_np};
        pf_count_reg <= {{(`COUNT_W-1){1'b0}}, take_pf};
        other_count_reg <= {{(`COUNT_W-1){1'b0}}, take_other};
      end else begin
        np_count_reg <= np_count_reg + {{(`COUNT_W-1){1'b0}}, take_np};
        pf_count_reg <= pf_count_reg + {{(`COUNT_W-1){1'b0}}, take_pf};
        other_count_reg <= other_count_reg +
                           {{(`COUNT_W-1){1'b0}}, take_other};
      end
      if (cpu_mem_valid) begin
        last_result_reg <= {take_pf, take_np};
      end
    end
  end

  // ==========================================================
  // AXI4-Lite read channel
  // ==========================================================
  assign s_axi_arready = !rvalid_reg;
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign ar_idx = s_axi_araddr[11:2];
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  // Read data select; narrow registers sit in the low bits
  always @* begin
    rdata_next = 32'h0000_0000;
    rresp_next = `RESP_OKAY;
    case (ar_idx)
      `NPW_BASE_IDX: begin
        rdata_next[15:0] = win_values[15:0];
      end
      `NPW_LIMIT_IDX: begin
        rdata_next[15:0] = win_values[31:16];
      end
      `PFW_BASE_IDX: begin
        rdata_next[15:0] = win_values[47:32];
      end
      `PFW_LIMIT_IDX: begin
        rdata_next[15:0] = win_values[63:48];
      end
      `DECODE_CTRL_IDX: begin
        rdata_next[`CTRL_ENABLE_BIT] = ctrl_reg[`CTRL_ENABLE_BIT];
      end
      `DECODE_STATUS_IDX: begin
        rdata_next[1:0] = last_result_reg;
        rdata_next[2] = np_hit;
        rdata_next[3] = pf_hit;
      end
      `NPW_COUNT_IDX: begin
        rdata_next[`COUNT_W-1:0] = np_count_reg;
      end
      `PFW_COUNT_IDX: begin
        rdata_next[`COUNT_W-1:0] = pf_count_reg;
      end
      `OTHER_COUNT_IDX: begin
        rdata_next[`COUNT_W-1:0] = other_count_reg;
      end
      default: begin
        rresp_next = `RESP_DECERR;
      end
    endcase
  end

  // Read answer registered at the address handshake
  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= `RESP_OKAY;
    end else if (ar_take) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

endmodule

// ---- bridge_window_defs.vh ----
/*
  Constants for the bridge memory window decode: register indices,
  byte addresses, field positions, reset values and bus answers.
  Assumes it is included by bare name into each design file that needs it.
*/
`ifndef BRIDGE_WINDOW_DEFS_VH
`define BRIDGE_WINDOW_DEFS_VH

// ==========================================================
// Register indices; byte address is four times the index
// ==========================================================
`define NPW_BASE_IDX 10'h020
`define NPW_LIMIT_IDX 10'h022
`define PFW_BASE_IDX 10'h024
`define PFW_LIMIT_IDX 10'h026
`define DECODE_CTRL_IDX 10'h028
`define DECODE_STATUS_IDX 10'h029
`define NPW_COUNT_IDX 10'h02a
`define PFW_COUNT_IDX 10'h02b
`define OTHER_COUNT_IDX 10'h02c

// ==========================================================
// Window register layout
// ==========================================================
`define WIN_FIELD_LSB 4
`define WIN_FIELD_W 12
`define WIN_LOW_ZERO 4'h0
`define WIN_BASE_RESET 16'hfff0
`define WIN_LIMIT_RESET 16'h0000
`define WIN_BASE_FILL 20'h0_0000
`define WIN_LIMIT_FILL 20'hf_ffff

// ==========================================================
// Own control and status layout
// ==========================================================
`define CTRL_ENABLE_BIT 0
`define CTRL_CLEAR_BIT 1
`define CTRL_RESET 2'h1
`define COUNT_W 16

// ==========================================================
// AXI4-Lite answers
// ==========================================================
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3
`define ADDR_W 12

`endif

// ---- window_field.v ----
/*
  One base or limit window register: a 12-bit field that software
  writes through two byte lanes; the low four bits are constant zero.
  Assumes a synchronous active-low reset and a one-cycle write strobe.
*/
`timescale 1ns/100ps
`include "bridge_window_defs.vh"

module window_field #(
  parameter [15:0] RESET_VALUE = `WIN_LIMIT_RESET
) (
  input wire aclk,
  input wire aresetn,
  input wire wr_en,
  input wire [1:0] wr_strb,
  input wire [15:0] wr_data,
  output wire [15:0] reg_value
);

  reg [11:0] field_reg;

  // ==========================================================
  // Field storage, byte lanes honoured
  // ==========================================================
  always @(posedge aclk) begin
    if (!aresetn) begin
      field_reg <= RESET_VALUE[15:4];
    end else if (wr_en) begin
      if (wr_strb[0]) begin
        field_reg[3:0] <= wr_data[7:4];
      end
      if (wr_strb[1]) begin
        field_reg[11:4] <= wr_data[15:8];
      end
    end
  end

  // Low nibble never stored, so writes there vanish
  assign reg_value = {field_reg, `WIN_LOW_ZERO};

endmodule

// ---- window_match.v ----
/*
  Inclusive range compare of a 32-bit address against one window.
  Assumes base and limit fields stand for address bits 31 to 20.
*/
`timescale 1ns/100ps
`include "bridge_window_defs.vh"

module window_match (
  input wire [31:0] addr,
  input wire [11:0] base_field,
  input wire [11:0] limit_field,
  output wire hit
);

  wire [31:0] lower_bound;
  wire [31:0] upper_bound;

  // ==========================================================
  // Bounds widened to full addresses
  // ==========================================================
  assign lower_bound = {base_field, `WIN_BASE_FILL};
  assign upper_bound = {limit_field, `WIN_LIMIT_FILL};

  // Base above limit gives an empty window, no special case needed
  assign hit = (addr >= lower_bound) && (addr <= upper_bound);

endmodule

// ---- bridge_memory_window_decode_properties.sv ----
/*
  Checker for the memory window decode: route timing and route flags,
  plus bus-side readiness.
  Assumes it is bound to the decode top module and sees only its ports.
*/
`timescale 1ns/100ps

module window_decode_checker (
  input wire aclk,
  input wire aresetn,
  input wire cpu_mem_valid,
  input wire [31:0] cpu_mem_addr,
  input wire route_valid,
  input wire [31:0] route_addr,
  input wire route_to_secondary,
  input wire route_to_other,
  input wire write_combining_attr,
  input wire uncached_attr,
  input wire s_axi_awready,
  input wire s_axi_bvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid
);
  // ==========================================================
  // Route decision
  // ==========================================================
  // One clock and one reset, so both are given once here
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_pulse; cpu_mem_valid |=> route_valid; endproperty
  a_pulse: assert property (p_pulse) else $error("no route pulse");
  property p_quiet; !cpu_mem_valid |=> !route_valid; endproperty
  a_quiet: assert property (p_quiet) else $error("stray route pulse");
  property p_addr; cpu_mem_valid |=> route_addr == $past(cpu_mem_addr); endproperty
  a_addr: assert property (p_addr) else $error("route address wrong");
  property p_one; route_valid |-> route_to_secondary != route_to_other; endproperty
  a_one: assert property (p_one) else $error("route flags not exclusive");
  property p_attr; route_to_secondary |-> write_combining_attr ^ uncached_attr; endproperty
  a_attr: assert property (p_attr) else $error("forwarded without one attr");
  property p_noattr; route_to_other |-> !write_combining_attr && !uncached_attr; endproperty
  a_noattr: assert property (p_noattr) else $error("attr on unrouted access");
  property p_idle; !route_valid |-> !route_to_secondary && !route_to_other; endproperty
  a_idle: assert property (p_idle) else $error("route flag without pulse");

  // ==========================================================
  // Register bus
  // ==========================================================
  property p_rbusy; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_rbusy: assert property (p_rbusy) else $error("read taken while answer stands");
  property p_wbusy; s_axi_bvalid |-> !s_axi_awready; endproperty
  a_wbusy: assert property (p_wbusy) else $error("write taken while answer stands");
endmodule

bind bridge_memory_window_decode window_decode_checker chk_u (
  .aclk(aclk),
  .aresetn(aresetn),
  .cpu_mem_valid(cpu_mem_valid),
  .cpu_mem_addr(cpu_mem_addr),
  .route_valid(route_valid),
  .route_addr(route_addr),
  .route_to_secondary(route_to_secondary),
  .route_to_other(route_to_other),
  .write_combining_attr(write_combining_attr),
  .uncached_attr(uncached_attr),
  .s_axi_awready(s_axi_awready),
  .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid)
);

// ---- cpu_access_source.sv ----
/*
  Processor side model: issues one memory access at a time.
  Assumes the decode needs no back-pressure and latches each access.
*/
`timescale 1ns/100ps

module cpu_access_source (
  input wire aclk,
  output logic cpu_mem_valid,
  output logic [31:0] cpu_mem_addr
);
  // ==========================================================
  // Access driver
  // ==========================================================
  initial begin
    cpu_mem_valid = 1'b0;
    cpu_mem_addr = 32'h0000_0000;
  end

  // Idle address is inverted so a stale value never looks valid
  task automatic issue(input logic [31:0] a);
    @(posedge aclk);
    cpu_mem_valid <= 1'b1;
    cpu_mem_addr <= a;
    @(posedge aclk);
    cpu_mem_valid <= 1'b0;
    cpu_mem_addr <= ~a;
    #1;
  endtask
endmodule

// ---- tb_bridge_memory_window_decode.sv ----
/*
  Self-checking bench for the memory window decode.
  Assumes the processor model drives accesses and the bench is the
  configuration software on the register bus.
*/
`timescale 1ns/100ps
`include "bridge_window_defs.vh"

module tb_bridge_memory_window_decode;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] awaddr = 12'h000;
  logic awvalid = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'hf;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic [11:0] araddr = 12'h000;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  wire awready, wready, bvalid, arready, rvalid, cpu_valid;
  wire route_valid, to_sec, to_other, wc_attr, uc_attr;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata, cpu_addr, route_addr;
  int error_cnt = 0;
  int n_tests = 0;
  localparam logic [11:0] NB = {`NPW_BASE_IDX, 2'b00};
  localparam logic [11:0] NL = {`NPW_LIMIT_IDX, 2'b00};
  localparam logic [11:0] PB = {`PFW_BASE_IDX, 2'b00};
  localparam logic [11:0] PL = {`PFW_LIMIT_IDX, 2'b00};
  localparam logic [11:0] CT = {`DECODE_CTRL_IDX, 2'b00};
  localparam logic [11:0] ST = {`DECODE_STATUS_IDX, 2'b00};
  localparam logic [11:0] CN = {`NPW_COUNT_IDX, 2'b00};
  localparam logic [11:0] CP = {`PFW_COUNT_IDX, 2'b00};
  localparam logic [11:0] CO = {`OTHER_COUNT_IDX, 2'b00};

  always #12.5 aclk = ~aclk;

  bridge_memory_window_decode dut_u (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .cpu_mem_valid(cpu_valid), .cpu_mem_addr(cpu_addr),
    .route_valid(route_valid), .route_addr(route_addr), .route_to_secondary(to_sec),
    .route_to_other(to_other), .write_combining_attr(wc_attr), .uncached_attr(uc_attr)
  );

  cpu_access_source src_u (.aclk(aclk), .cpu_mem_valid(cpu_valid), .cpu_mem_addr(cpu_addr));

  // ==========================================================
  // Shared tasks
  // ==========================================================
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic give_up();
    error_cnt++;
    $display("[FAIL] %0t bus answer never came", $time);
    wrap_up();
  endtask

  // Address and data offered together, each dropped when taken;
  // handshakes are read mid-cycle, so they are the values the edge takes
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    bit ok;
    bit aw_ok;
    bit w_ok;
    logic [1:0] resp;
    ok = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int i = 0; i < 40 && !ok; i++) begin
      @(negedge aclk);
      aw_ok = (awready === 1'b1);
      w_ok = (wready === 1'b1);
      ok = (bvalid === 1'b1);
      resp = bresp;
      @(posedge aclk);
      if (aw_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
      if (ok) begin
        bready <= 1'b0;
        check({30'h0, resp}, {30'h0, er});
      end
    end
    if (!ok) give_up();
  endtask

  task automatic axi_rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    bit ok;
    bit ar_ok;
    logic [31:0] data;
    logic [1:0] resp;
    ok = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int i = 0; i < 40 && !ok; i++) begin
      @(negedge aclk);
      ar_ok = (arready === 1'b1);
      ok = (rvalid === 1'b1);
      data = rdata;
      resp = rresp;
      @(posedge aclk);
      if (ar_ok) arvalid <= 1'b0;
      if (ok) begin
        rready <= 1'b0;
        check(data, ed);
        check({30'h0, resp}, {30'h0, er});
      end
    end
    if (!ok) give_up();
  endtask

  // Expected flags packed as secondary, write combining, uncached
  task automatic probe(input logic [31:0] a, input logic [2:0] e);
    src_u.issue(a);
    check({28'h0, route_valid, to_sec, wc_attr, uc_attr}, {28'h1, e});
    check({31'h0, to_other}, {31'h0, ~e[2]});
    check(route_addr, a);
  endtask

  // ==========================================================
  // Scenarios
  // ==========================================================
  task automatic t_reset();
    axi_rd(NB, 32'h0000_fff0, `RESP_OKAY);
    axi_rd(NL, 32'h0000_0000, `RESP_OKAY);
    axi_rd(PB, 32'h0000_fff0, `RESP_OKAY);
    axi_rd(PL, 32'h0000_0000, `RESP_OKAY);
    probe(32'h0000_0000, 3'b000);
    probe(32'hfff0_0000, 3'b000);
    $display("Test reset done");
  endtask

  // Low nibble and upper half written as ones must not stick
  task automatic t_fields();
    axi_wr(NB, 32'hffff_abcf, `RESP_OKAY);
    axi_rd(NB, 32'h0000_abc0, `RESP_OKAY);
    axi_wr(PL, 32'h0000_000f, `RESP_OKAY);
    axi_rd(PL, 32'h0000_0000, `RESP_OKAY);
    wstrb <= 4'h1;
    axi_wr(NB, 32'h0000_0050, `RESP_OKAY);
    wstrb <= 4'hf;
    axi_rd(NB, 32'h0000_ab50, `RESP_OKAY);
    $display("Test fields done");
  endtask

  // Both windows set, kept apart, then probed at every edge
  task automatic t_windows();
    axi_wr(NB, 32'h0000_1230, `RESP_OKAY);
    axi_wr(NL, 32'h0000_1250, `RESP_OKAY);
    axi_wr(PB, 32'h0000_4000, `RESP_OKAY);
    axi_wr(PL, 32'h0000_4000, `RESP_OKAY);
    probe(32'h122f_ffff, 3'b000);
    probe(32'h1230_0000, 3'b101);
    probe(32'h125f_ffff, 3'b101);
    probe(32'h1260_0000, 3'b000);
    probe(32'h3fff_ffff, 3'b000);
    probe(32'h4000_0000, 3'b110);
    probe(32'h400f_ffff, 3'b110);
    probe(32'h4010_0000, 3'b000);
    $display("Test windows done");
  endtask

  // Counts left by earlier scenarios, then clear, then decode switched off
  task automatic t_stats();
    axi_rd(CN, 32'h0000_0002, `RESP_OKAY);
    axi_rd(CP, 32'h0000_0002, `RESP_OKAY);
    axi_rd(CO, 32'h0000_0006, `RESP_OKAY);
    axi_wr(CT, 32'h0000_0003, `RESP_OKAY);
    axi_rd(CO, 32'h0000_0000, `RESP_OKAY);
    probe(32'h1230_0000, 3'b101);
    axi_rd(ST, 32'h0000_0001, `RESP_OKAY);
    axi_wr(CT, 32'h0000_0000, `RESP_OKAY);
    axi_rd(CT, 32'h0000_0000, `RESP_OKAY);
    probe(32'h1230_0000, 3'b000);
    axi_rd(CO, 32'h0000_0001, `RESP_OKAY);
    axi_wr(CT, 32'h0000_0001, `RESP_OKAY);
    axi_rd(CT, 32'h0000_0001, `RESP_OKAY);
    $display("Test stats done");
  endtask

  task automatic t_unmapped();
    axi_wr(12'h0fc, 32'h0000_ffff, `RESP_DECERR);
    axi_rd(12'h0fc, 32'h0000_0000, `RESP_DECERR);
    $display("Test unmapped done");
  endtask

  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_fields();
    t_windows();
    t_stats();
    t_unmapped();
    wrap_up();
  end
endmodule
